// ==== bench/hioc_host_model.sv ====
`timescale 1ns/10ps
module hioc_host_model
(
    input wire logic pin_o, // pin drive value
    input wire logic pin_oe, // pin output enable
    output logic pin_wire // level the host sees
);
    // the host board pulls the line up whenever nobody drives it
    assign pin_wire = pin_oe ? pin_o : 1'b1;
endmodule : hioc_host_model

// ==== bench/host_interrupt_output_control_tb_top.sv ====
`timescale 1ns/10ps
`include "hioc_regs.svh"
module host_interrupt_output_control_tb_top
    import hioc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    hioc_chan_in_t chan_in = '0;
    logic fault_req = 1'b0;
    logic warm_restart = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, pin_o, pin_oe, pin_wire, irq;
    logic [3:0] chan_flush, discard_block;
    logic [3:0] flush_seen = 4'h0;
    logic [3:0] disc_seen = 4'h0;
    logic [7:0] q;
    int miscompares = 0;
    int n_tests = 0;

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        flush_seen <= flush_seen | chan_flush;
        disc_seen <= disc_seen | discard_block;
    end

    hioc_top hioc_top_inst
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chan_in(chan_in), .fault_req(fault_req),
        .warm_restart(warm_restart), .host_irq_pin_o(pin_o), .host_irq_pin_oe(pin_oe),
        .chan_flush(chan_flush), .discard_block(discard_block), .irq(irq)
    );
    hioc_host_model hioc_host_model_inst
    (
        .pin_o(pin_o), .pin_oe(pin_oe), .pin_wire(pin_wire)
    );

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // entered just after an edge; holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic ev(input int ch, input logic dn);
        if (dn) chan_in.done[ch] <= 1'b1;
        else chan_in.req[ch] <= 1'b1;
        @(posedge ref_clk);
        chan_in.done <= 4'h0;
        chan_in.req <= 4'h0;
    endtask : ev

    task automatic pin(input logic exp, input string nm);
        cyc(4);
        chk(nm, 16'(exp), 16'(pin_wire));
    endtask : pin

    task automatic s_boot;
        bus(1'b0, `HIOC_CFG_IDX, 8'h00);
        chk("cfg reset", 16'(`HIOC_CFG_RST), 16'(q));
        bus(1'b0, 8'hFF, 8'h00);
        chk("unmapped read", 16'h0, 16'(q));
        ev(1, 1'b0);
        pin(1'b0, "pin before fw");
        bus(1'b1, `HIOC_SYSCTL_IDX, 8'h01);
        q = 8'h00;
        for (int n = 0; n < 20 && q[0] !== 1'b1; n++) bus(1'b0, `HIOC_SYSCTL_IDX, 8'h00);
        pin(1'b1, "pin after fw");
        chk("irq raised", 16'h1, 16'(irq));
        bus(1'b1, `HIOC_IMASK_IDX, 8'h0F);
        cyc(3);
        chk("irq masked", 16'h0, 16'(irq));
        bus(1'b1, `HIOC_IMASK_IDX, 8'h00);
        bus(1'b0, `HIOC_ISTAT_IDX, 8'h00);
        chk("status set", 16'h1, 16'(q[0]));
        bus(1'b0, `HIOC_ISTAT_IDX, 8'h00);
        chk("status cleared", 16'h0, 16'(q[0]));
        cyc(3);
        chk("irq cleared", 16'h0, 16'(irq));
        ev(1, 1'b1);
        pin(1'b0, "pin after done");
    endtask : s_boot

    task automatic s_mask;
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, `HIOC_HICTL_IDX, (i == 3) ? 8'h80 : 8'h00);
            bus(1'b1, `HIOC_CFG_IDX, 8'h01 << i);
            if (i == 4) fault_req <= 1'b1;
            else ev((i > 1) ? 3 : i + 1, 1'b0);
            pin(1'b0, "pin masked");
            bus(1'b1, `HIOC_CFG_IDX, 8'h00);
            pin(1'b1, "pin unmasked");
            if (i == 1)
            begin
                bus(1'b1, `HIOC_HICTL_IDX, 8'h10);
                pin(1'b0, "pin host asleep");
                bus(1'b1, `HIOC_HICTL_IDX, 8'h00);
                pin(1'b1, "pin host awake");
            end
            fault_req <= 1'b0;
            ev((i > 1) ? 3 : i + 1, 1'b1);
            pin(1'b0, "pin source gone");
        end
        bus(1'b1, `HIOC_CFG_IDX, 8'h1F);
        fault_req <= 1'b1;
        ev(1, 1'b0);
        pin(1'b0, "pin all masked");
        fault_req <= 1'b0;
        ev(1, 1'b1);
        bus(1'b1, `HIOC_CFG_IDX, 8'h00);
    endtask : s_mask

    task automatic s_drive;
        // per config: idle wire, idle enable, active wire, active enable
        logic [7:0] c [3] = '{8'h20, 8'hA0, 8'h80};
        logic [3:0] e [3] = '{4'b1101, 4'b1001, 4'b0110};
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, `HIOC_CFG_IDX, c[i]);
            cyc(3);
            chk("idle pin", 16'(e[i][3:2]), 16'({pin_wire, pin_oe}));
            ev(1, 1'b0);
            cyc(3);
            chk("active pin", 16'(e[i][1:0]), 16'({pin_wire, pin_oe}));
            ev(1, 1'b1);
        end
    endtask : s_drive

    task automatic s_pulse;
        int n;
        bus(1'b1, `HIOC_CFG_IDX, 8'h40);
        ev(1, 1'b0);
        n = 0;
        while (pin_wire !== 1'b1 && n < 10)
        begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (pin_wire === 1'b1 && n < 1100)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("pulse length", 16'(`HIOC_PULSE_CYC), 16'(n));
        pin(1'b0, "no retrigger");
        ev(1, 1'b1);
    endtask : s_pulse

    task automatic s_abort;
        bus(1'b1, `HIOC_CFG_IDX, 8'h00);
        chan_in.tx_short[2] <= 1'b1;
        ev(2, 1'b0);
        pin(1'b1, "pin ch2 pending");
        // abort stays set for the rest of the run, well short of the host's hold time
        bus(1'b1, `HIOC_HICTL_IDX, 8'h04);
        cyc(4);
        chk("flush", 16'h4, 16'(flush_seen));
        chk("discard", 16'h4, 16'(disc_seen));
        chk("pin aborted", 16'h0, 16'(pin_wire));
        bus(1'b0, `HIOC_HICTL_IDX, 8'h00);
        chk("abort kept", 16'h4, 16'(q));
        ev(2, 1'b0);
        pin(1'b0, "pin abort held");
        ev(1, 1'b0);
        pin(1'b1, "pin other channel");
        ev(1, 1'b1);
        chan_in.tx_short[2] <= 1'b0;
    endtask : s_abort

    task automatic s_restart;
        bus(1'b1, `HIOC_CFG_IDX, 8'h21);
        warm_restart <= 1'b1;
        cyc(1);
        warm_restart <= 1'b0;
        bus(1'b0, `HIOC_CFG_IDX, 8'h00);
        chk("cfg kept", 16'h21, 16'(q));
        fault_req <= 1'b1;
        pin(1'b1, "pin in boot");
        bus(1'b1, `HIOC_SYSCTL_IDX, 8'h01);
        pin(1'b0, "pin after restart");
        fault_req <= 1'b0;
    endtask : s_restart

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        s_boot;
        s_mask;
        s_drive;
        s_pulse;
        s_abort;
        s_restart;
        tally_and_finish;
    end

    initial
    begin
        #500000;
        miscompares++;
        tally_and_finish;
    end
endmodule : host_interrupt_output_control_tb_top

// ==== pkg/hioc_pkg.sv ====
package hioc_pkg;
    typedef struct packed {
        logic open_drain;
        logic pulse_mode;
        logic active_low;
        logic [4:0] mask;
    } hioc_cfg_t;
    typedef struct packed {
        logic async_status;
        logic ts_select;
        logic rsvd;
        logic ap_suspended;
        logic [3:0] abort;
    } hioc_hictl_t;
    typedef struct packed {
        logic [3:0] req;
        logic [3:0] done;
        logic [3:0] tx_short;
        logic [3:0] blk_last32;
    } hioc_chan_in_t;
    typedef enum logic [1:0] {
        HIOC_BUS_IDLE,
        HIOC_BUS_ACK
    } hioc_bus_state_t;
endpackage : hioc_pkg

// ==== pkg/hioc_regs.svh ====
`ifndef HIOC_REGS_SVH
`define HIOC_REGS_SVH
// register indices; byte address is four times the index
`define HIOC_HICTL_IDX 8'h06
`define HIOC_CFG_IDX 8'h07
`define HIOC_ISTAT_IDX 8'h20
`define HIOC_IMASK_IDX 8'h21
`define HIOC_SYSCTL_IDX 8'h22
`define HIOC_SRCSTAT_IDX 8'h23
// reset values
`define HIOC_CFG_RST 8'h00
`define HIOC_HICTL_RST 8'h00
`define HIOC_IMASK_RST 4'h0
// writable bits of the host interface control register (bit 5 reserved)
`define HIOC_HICTL_WMASK 8'hDF
// field positions
`define HIOC_SYS_FW_BIT 0
`define HIOC_ISTAT_W 4
// timing
`define HIOC_CLK_NS 10
`define HIOC_PULSE_US 10
`define HIOC_PULSE_CYC ((`HIOC_PULSE_US * 1000) / `HIOC_CLK_NS)
`define HIOC_PULSE_W 10
`endif

// ==== rtl/hioc_pulse_gen.sv ====
`timescale 1ns/10ps
`include "hioc_regs.svh"
module hioc_pulse_gen
    import hioc_pkg::*;
(
    input wire logic ref_clk, // 100 MHz clock
    input wire logic reset_n, // async reset, active low
    input wire logic clr, // abandon any pulse in flight
    input wire logic trig, // start a pulse
    output logic busy // pulse in progress
);
    logic [`HIOC_PULSE_W-1:0] cnt_reg;
    logic busy_reg;
    localparam logic [`HIOC_PULSE_W-1:0] LOAD = `HIOC_PULSE_W'(`HIOC_PULSE_CYC - 1);
    wire cnt_zero = (cnt_reg == '0);

    // a trigger during a running pulse is ignored, one pulse per event
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else if (clr)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else if (trig && !busy_reg)
        begin
            busy_reg <= 1'b1;
            cnt_reg <= LOAD;
        end
        else if (busy_reg)
        begin
            busy_reg <= !cnt_zero;
            cnt_reg <= cnt_zero ? cnt_reg : cnt_reg - 1'b1;
        end
    end

    assign busy = busy_reg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_pulse_end;
        (busy_reg && cnt_zero && !clr) |=> !busy_reg;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end at count zero");
endmodule : hioc_pulse_gen

// ==== rtl/hioc_top.sv ====
`timescale 1ns/10ps
`include "hioc_regs.svh"
module hioc_top
    import hioc_pkg::*;
(
    input wire logic ref_clk, // 100 MHz clock
    input wire logic reset_n, // async reset, active low
    input wire logic [9:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [3:0] avs_byteenable, // byte lanes
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // low for the accepting cycle
    input wire hioc_chan_in_t chan_in, // per-channel fifo events
    input wire logic fault_req, // fault pending, level
    input wire logic warm_restart, // watchdog or fatal restart pulse
    output logic host_irq_pin_o, // interrupt pin drive value
    output logic host_irq_pin_oe, // interrupt pin output enable
    output logic [3:0] chan_flush, // clear channel buffer, pulse
    output logic [3:0] discard_block, // drop 32-byte block, pulse
    output logic irq // level interrupt to local cpu
);
    hioc_cfg_t cfg_reg;
    hioc_hictl_t hictl_reg;
    hioc_bus_state_t bus_reg;
    logic [31:0] rdata_reg;
    logic fw_ready_reg;
    logic [3:0] pend_reg;
    logic [3:0] abort_prev_reg;
    logic gated_prev_reg;
    logic fault_prev_reg;
    logic irq_active_reg;
    logic pin_o_reg;
    logic pin_oe_reg;
    logic [3:0] flush_reg;
    logic [3:0] discard_reg;
    logic [`HIOC_ISTAT_W-1:0] istat_reg;
    logic [`HIOC_ISTAT_W-1:0] imask_reg;
    logic irq_reg;
    logic pulse_busy;

    function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction : hit

    // bus decode; requests accepted in the cycle waitrequest is low
    wire bus_req = avs_read || avs_write;
    wire wr_ack = avs_write && (bus_reg == HIOC_BUS_ACK);
    wire rd_ack = avs_read && (bus_reg == HIOC_BUS_ACK);
    wire lane0 = avs_byteenable[0];
    wire cfg_wr = wr_ack && lane0 && hit(avs_address, `HIOC_CFG_IDX);
    wire hictl_wr = wr_ack && lane0 && hit(avs_address, `HIOC_HICTL_IDX);
    wire imask_wr = wr_ack && lane0 && hit(avs_address, `HIOC_IMASK_IDX);
    wire sys_wr = wr_ack && lane0 && hit(avs_address, `HIOC_SYSCTL_IDX);
    wire istat_rd = rd_ack && hit(avs_address, `HIOC_ISTAT_IDX);

    // request formation
    wire [3:0] abort_rise = hictl_reg.abort & ~abort_prev_reg;
    wire [3:0] discard_next = abort_rise & (chan_in.tx_short | chan_in.blk_last32);
    wire src_wake = pend_reg[1] && !cfg_reg.mask[0];
    wire src_nowake = pend_reg[2] && !cfg_reg.mask[1] && !hictl_reg.ap_suspended;
    wire src_sync = pend_reg[3] && !hictl_reg.async_status && !cfg_reg.mask[2];
    wire src_async = pend_reg[3] && hictl_reg.async_status && !cfg_reg.mask[3];
    wire src_fault = fault_req && !cfg_reg.mask[4];
    wire raw_req = src_wake || src_nowake || src_sync || src_async || src_fault;
    wire gated = fw_ready_reg && raw_req;
    wire pulse_trig = gated && !gated_prev_reg && cfg_reg.pulse_mode;
    // level mode follows the request, pulse mode follows the timer
    wire active_next = fw_ready_reg && (cfg_reg.pulse_mode ? pulse_busy : raw_req);
    wire lvl_next = active_next ^ cfg_reg.active_low;
    wire pin_o_next = cfg_reg.open_drain ? 1'b0 : lvl_next;
    wire pin_oe_next = cfg_reg.open_drain ? !lvl_next : 1'b1;
    // abort overrides a new request while held; otherwise a new request wins over a read-out
    wire [3:0] pend_next = ((pend_reg & ~chan_in.done) | chan_in.req) & ~hictl_reg.abort;

    // local interrupt events
    wire [`HIOC_ISTAT_W-1:0] ev = {(fault_req && !fault_prev_reg), (|abort_rise),
                                   (|discard_next), (gated && !gated_prev_reg)};
    wire [`HIOC_ISTAT_W-1:0] istat_clr = istat_rd ? rdata_reg[`HIOC_ISTAT_W-1:0] : '0;
    wire [`HIOC_ISTAT_W-1:0] istat_next = ev | (istat_reg & ~istat_clr);

    wire [31:0] rd_mux =
        hit(avs_address, `HIOC_CFG_IDX) ? {24'h000000, cfg_reg} :
        hit(avs_address, `HIOC_HICTL_IDX) ? {24'h000000, hictl_reg} :
        hit(avs_address, `HIOC_ISTAT_IDX) ? {28'h0000000, istat_reg} :
        hit(avs_address, `HIOC_IMASK_IDX) ? {28'h0000000, imask_reg} :
        hit(avs_address, `HIOC_SYSCTL_IDX) ? {31'h0, fw_ready_reg} :
        hit(avs_address, `HIOC_SRCSTAT_IDX) ? {25'h0, irq_active_reg, raw_req,
                                              pend_reg, fault_req} :
        32'h00000000;

    hioc_pulse_gen hioc_pulse_gen_inst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clr(!fw_ready_reg),
        .trig(pulse_trig),
        .busy(pulse_busy)
    );

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_reg <= HIOC_BUS_IDLE;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            bus_reg <= (bus_req && bus_reg == HIOC_BUS_IDLE) ? HIOC_BUS_ACK : HIOC_BUS_IDLE;
            rdata_reg <= (bus_req && bus_reg == HIOC_BUS_IDLE) ? rd_mux : rdata_reg;
        end
    end

    // configuration survives a warm restart, only reset_n clears it
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            cfg_reg <= `HIOC_CFG_RST;
        else if (cfg_wr)
            cfg_reg <= avs_writedata[7:0];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            hictl_reg <= `HIOC_HICTL_RST;
        else if (hictl_wr)
            hictl_reg <= avs_writedata[7:0] & `HIOC_HICTL_WMASK;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            fw_ready_reg <= 1'b0;
        else if (warm_restart)
            fw_ready_reg <= 1'b0;
        else if (sys_wr)
            fw_ready_reg <= avs_writedata[`HIOC_SYS_FW_BIT];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_reg <= 4'h0;
            abort_prev_reg <= 4'h0;
            flush_reg <= 4'h0;
            discard_reg <= 4'h0;
        end
        else
        begin
            pend_reg <= pend_next;
            abort_prev_reg <= hictl_reg.abort;
            flush_reg <= abort_rise;
            discard_reg <= discard_next;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gated_prev_reg <= 1'b0;
            fault_prev_reg <= 1'b0;
            irq_active_reg <= 1'b0;
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b1;
        end
        else
        begin
            gated_prev_reg <= gated;
            fault_prev_reg <= fault_req;
            irq_active_reg <= active_next;
            pin_o_reg <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            istat_reg <= '0;
            imask_reg <= `HIOC_IMASK_RST;
            irq_reg <= 1'b0;
        end
        else
        begin
            istat_reg <= istat_next;
            imask_reg <= imask_wr ? avs_writedata[`HIOC_ISTAT_W-1:0] : imask_reg;
            irq_reg <= |(istat_next & ~imask_reg);
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = (bus_reg != HIOC_BUS_ACK);
    assign host_irq_pin_o = pin_o_reg;
    assign host_irq_pin_oe = pin_oe_reg;
    assign chan_flush = flush_reg;
    assign discard_block = discard_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_hold_level;
        (fw_ready_reg && !cfg_reg.pulse_mode && raw_req) |=> irq_active_reg;
    endproperty
    a_hold_level: assert property (p_hold_level) else $error("level irq dropped");

    property p_abort_sticky;
        (!hictl_wr) |=> $stable(hictl_reg.abort);
    endproperty
    a_abort_sticky: assert property (p_abort_sticky) else $error("abort bits changed");

    property p_discard;
        (abort_rise[2] && (chan_in.tx_short[2] || chan_in.blk_last32[2])) |=> discard_block[2];
    endproperty
    a_discard: assert property (p_discard) else $error("block not discarded");

    property p_no_boot_irq;
        (!fw_ready_reg && !cfg_wr) |=> (!irq_active_reg &&
            host_irq_pin_o == (cfg_reg.active_low && !cfg_reg.open_drain));
    endproperty
    a_no_boot_irq: assert property (p_no_boot_irq) else $error("irq before ready");

    property p_warm_keep;
        (warm_restart && !cfg_wr) |=> ($stable(cfg_reg) && !fw_ready_reg);
    endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("restart lost config");

    property p_all_masked;
        (&cfg_reg.mask) |-> !raw_req;
    endproperty
    a_all_masked: assert property (p_all_masked) else $error("masked source raised");

    property p_push_pull;
        (!cfg_reg.open_drain && !cfg_wr) |=> (host_irq_pin_oe &&
            host_irq_pin_o == (irq_active_reg ^ $past(cfg_reg.active_low)));
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull level wrong");

    property p_open_drain;
        (cfg_reg.open_drain && !cfg_wr) |=> (!host_irq_pin_o &&
            host_irq_pin_oe == !(irq_active_reg ^ $past(cfg_reg.active_low)));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain wrong");

    property p_pulse_len;
        ($rose(irq_active_reg) && cfg_reg.pulse_mode && fw_ready_reg && !warm_restart)
            |-> irq_active_reg [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse too short");

    property p_abort_clear;
        abort_rise[2] |=> (!pend_reg[2] && chan_flush[2]);
    endproperty
    a_abort_clear: assert property (p_abort_clear) else $error("abort kept pending");

    property p_pend_hold;
        (pend_reg[1] && !chan_in.done[1] && !hictl_reg.abort[1]) |=> pend_reg[1];
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending dropped");

    property p_pend_read;
        (pend_reg[1] && chan_in.done[1] && !chan_in.req[1]) |=> !pend_reg[1];
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending kept");

    property p_keep_other;
        (hictl_reg.abort[2] && !hictl_reg.abort[1] && chan_in.req[1]) |=> pend_reg[1];
    endproperty
    a_keep_other: assert property (p_keep_other) else $error("other channel lost");

    property p_abort_hold;
        hictl_reg.abort[2] |=> !pend_reg[2];
    endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("pending while abort");

    property p_cfg_write;
        cfg_wr |=> (cfg_reg == $past(avs_writedata[7:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config not written");

    property p_abort_wr;
        hictl_wr |=> (hictl_reg.abort == $past(avs_writedata[3:0]));
    endproperty
    a_abort_wr: assert property (p_abort_wr) else $error("abort not written");

    property p_boot_quiet;
        (!fw_ready_reg) |=> !pulse_busy;
    endproperty
    a_boot_quiet: assert property (p_boot_quiet) else $error("pulse during boot");

    property p_level_drop;
        (fw_ready_reg && !cfg_reg.pulse_mode && !raw_req) |=> !irq_active_reg;
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level irq stuck");

    property p_pulse_go;
        (pulse_trig && !pulse_busy) |=> pulse_busy;
    endproperty
    a_pulse_go: assert property (p_pulse_go) else $error("pulse not started");

    property p_stat_set;
        (|ev) |=> ((istat_reg & $past(ev)) == $past(ev));
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("status not set");

    property p_flush_once;
        chan_flush[2] |=> !chan_flush[2];
    endproperty
    a_flush_once: assert property (p_flush_once) else $error("flush too long");

    property p_disc_flush;
        discard_block[2] |-> chan_flush[2];
    endproperty
    a_disc_flush: assert property (p_disc_flush) else $error("discard without flush");

    property p_fault_irq;
        (fw_ready_reg && !cfg_reg.pulse_mode && fault_req && !cfg_reg.mask[4]) |=> irq_active_reg;
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("fault not raised");

    property p_warm_off;
        warm_restart |=> ##1 !irq_active_reg;
    endproperty
    a_warm_off: assert property (p_warm_off) else $error("irq after restart");

    c_level_irq: cover property (fw_ready_reg && !cfg_reg.pulse_mode ##1 $rose(irq_active_reg));
    c_pulse_irq: cover property (cfg_reg.pulse_mode && $rose(irq_active_reg));
    c_abort: cover property (|discard_block);
    c_od_low: cover property (cfg_reg.open_drain && cfg_reg.active_low && host_irq_pin_oe);
    c_warm: cover property (warm_restart ##1 !fw_ready_reg);
endmodule : hioc_top
